// ### rtdt_pkg.sv
package rtdt_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL       = 8'h07;
	localparam logic [7:0] ADDR_TRIM       = 8'h08;
	localparam logic [7:0] CTRL_RST        = 8'h00;
	localparam logic [7:0] TRIM_RST        = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int         TRIM_SIGN_BIT   = 7;
	localparam int         CTRL_SQUARE_WAVE_OUTPUT_ENABLE_BIT  = 6;
	localparam int         CTRL_EXTERNAL_CLOCK_INPUT_SELECT_BIT = 3;
	localparam int         CTRL_CRS_BIT    = 2;

	// ****************************************
	// timebase
	// ****************************************
	localparam int         OSC_HZ          = 32768;
	localparam int         COARSE_HZ       = 128;
	localparam int         COARSE_TICKS    = OSC_HZ / COARSE_HZ;
	localparam int         CYC_PER_STEP    = 2;
	localparam int         SEC_PER_MIN     = 60;
	localparam int         PRESC_W         = 15;
	localparam int         SQW_1HZ_BIT     = 14;
	localparam int         SQW_4K_BIT      = 2;
	localparam int         SQW_8K_BIT      = 1;
	localparam int         SQW_64HZ_BIT    = 8;
	localparam logic [7:0] PEND_MAX        = 8'hfe;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       sign;
		logic [6:0] step;
	} rtdt_trim_t;

	typedef struct packed {
		logic       gp_out;
		logic       square_wave_output_enable;
		logic       alm1en;
		logic       alm0en;
		logic       external_clock_input_select;
		logic       coarse;
		logic [1:0] square_wave_freq_select;
	} rtdt_ctrl_t;

	typedef enum logic [1:0] {
		SQW_1HZ,
		SQW_4K,
		SQW_8K,
		SQW_32K
	} rtdt_sqw_t;

endpackage : rtdt_pkg

// ### rtdt_wrap_cnt.sv
`timescale 1ns/1ps
module rtdt_wrap_cnt
	import rtdt_pkg::*;
#(
	parameter int MODULO = 60
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	// count
	input  wire logic                      step,
	output logic [$clog2(MODULO)-1:0]      count,
	output logic                           wrap
);

	localparam int CW = $clog2(MODULO);
	localparam logic [CW-1:0] LAST = CW'(MODULO - 1);

	initial begin
		if (MODULO < 2) $error("modulo must be at least two");
	end

	logic [CW-1:0] cnt_q;

	assign wrap  = step && (cnt_q == LAST);
	assign count = cnt_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (wrap) begin
			cnt_q <= '0;
		end else if (step) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule : rtdt_wrap_cnt

// ### rtdt_trim.sv
`timescale 1ns/1ps
// Overview of operation
// - with coarse mode off, apply correction exactly once per minute
// - trim bit 7 set adds cycles for slow time, clear removes them
// - each step count unit equals two oscillator cycles per correction
// - step count zero means no cycles added or removed at all
// - trimming continues unchanged while running from backup supply
// - normal mode maximum step gives 254 cycles per minute, linear
// - coarse mode applies the correction at 128 Hz
// - coarse mode maximum step gives 254 cycles per 128 Hz event
// - coarse mode with square wave enabled drives trimmed 64 Hz on pin
// - no coarse 64 Hz square wave on pin while on backup supply
// - trim register read/write at 0x08, resets to zero, sign and count
// - control holds coarse bit 2, sqw enable 6, ext clock 3, freq 1:0
module rtdt_trim
	import rtdt_pkg::*;
#(
	parameter int MIN_SECONDS = SEC_PER_MIN
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// oscillator sources, one-cycle pulses per oscillator cycle
	input  wire logic        xtal_tick,
	input  wire logic        ext_tick,
	input  wire logic        osc_level,
	input  wire logic        oscillator_start,
	input  wire logic        on_backup,
	// register port
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// timebase
	output logic             sec_tick,
	output logic             min_tick,
	// multi_function_pin, open drain
	output logic             mfp_o,
	output logic             mfp_oe
);

	initial begin
		if (MIN_SECONDS < 2) $error("minute length too short");
	end

	// ****************************************
	// registers
	// ****************************************
	rtdt_trim_t trim_q;
	rtdt_ctrl_t ctrl_q;
	logic [7:0] rdata_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			trim_q <= rtdt_trim_t'(TRIM_RST);
		end else if (reg_wr && reg_addr == ADDR_TRIM) begin
			trim_q <= rtdt_trim_t'(reg_wdata);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= rtdt_ctrl_t'(CTRL_RST);
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_q <= rtdt_ctrl_t'(reg_wdata);
		end
	end

	// unmapped addresses read as zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else if (reg_addr == ADDR_TRIM) begin
			rdata_q <= trim_q;
		end else if (reg_addr == ADDR_CTRL) begin
			rdata_q <= ctrl_q;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// prescaler with trim
	// ****************************************
	logic               tick;
	logic [PRESC_W-1:0] presc_q;
	logic [7:0]         pend_q;
	logic [8:0]         inc;
	logic [PRESC_W:0]   presc_sum;
	logic [8:0]         low_sum;
	logic               sec_carry;
	logic               c128;
	logic               min_wrap;
	logic               corr_evt;

	// no power gating here: backup only affects the pin driver
	assign tick = oscillator_start && (ctrl_q.external_clock_input_select ? ext_tick : xtal_tick);

	// adds land in one jump on the tick after the event, so even 254 added
	// cycles stay inside one 256-tick coarse slot; removals swallow ticks
	always_comb begin
		inc = 9'h000;
		if (tick) begin
			if (pend_q == 8'h00) begin
				inc = 9'h001;
			end else if (trim_q.sign) begin
				inc = {1'b0, pend_q} + 9'h001;
			end else begin
				inc = 9'h000;
			end
		end
	end

	assign presc_sum = {1'b0, presc_q} + {{(PRESC_W-8){1'b0}}, inc};
	assign low_sum   = {1'b0, presc_q[7:0]} + inc;
	assign sec_carry = presc_sum[PRESC_W];
	assign c128      = low_sum[8];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_sum[PRESC_W-1:0];
		end
	end

	rtdt_wrap_cnt #(
		.MODULO  (MIN_SECONDS)
	) u_sec (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.step    (sec_carry),
		.count   (),
		.wrap    (min_wrap)
	);

	assign corr_evt = ctrl_q.coarse ? c128 : min_wrap;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 8'h00;
		end else if (corr_evt) begin
			pend_q <= {trim_q.step, 1'b0};
		end else if (tick && trim_q.sign) begin
			pend_q <= 8'h00;
		end else if (tick && pend_q != 8'h00) begin
			pend_q <= pend_q - 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
		end else begin
			sec_tick <= sec_carry;
			min_tick <= min_wrap;
		end
	end

	// ****************************************
	// square wave on the pin
	// ****************************************
	logic sqw_lvl;

	always_comb begin
		sqw_lvl = 1'b0;
		if (ctrl_q.coarse) begin
			sqw_lvl = presc_q[SQW_64HZ_BIT];
		end else begin
			unique case (rtdt_sqw_t'(ctrl_q.square_wave_freq_select))
				SQW_1HZ: sqw_lvl = presc_q[SQW_1HZ_BIT];
				SQW_4K:  sqw_lvl = presc_q[SQW_4K_BIT];
				SQW_8K:  sqw_lvl = presc_q[SQW_8K_BIT];
				SQW_32K: sqw_lvl = osc_level;
			endcase
		end
	end

	// open drain: pull low for a low level, release otherwise
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mfp_oe <= 1'b0;
		end else begin
			mfp_oe <= ctrl_q.square_wave_output_enable && !on_backup && !sqw_lvl;
		end
	end

	assign mfp_o = 1'b0;

	// ****************************************
	// checks
	// ****************************************
	sequence s_step_add;
		tick && pend_q != 8'h00 && trim_q.sign;
	endsequence

	sequence s_step_sub;
		tick && pend_q != 8'h00 && !trim_q.sign;
	endsequence

	property p_minute_event;
		@(posedge sys_clk) disable iff (!arst_n)
		corr_evt && !ctrl_q.coarse |-> min_wrap && sec_carry;
	endproperty
	a_minute_event: assert property (p_minute_event)
		else $error("normal correction off the minute rollover");

	property p_add;
		@(posedge sys_clk) disable iff (!arst_n)
		s_step_add |=> presc_q ==
			PRESC_W'($past(presc_q) + PRESC_W'($past(pend_q)) + PRESC_W'(1));
	endproperty
	a_add: assert property (p_add)
		else $error("add step did not jump by the pending cycles");

	property p_add_clear;
		@(posedge sys_clk) disable iff (!arst_n)
		s_step_add |=> pend_q == 8'h00;
	endproperty
	a_add_clear: assert property (p_add_clear)
		else $error("added cycles left pending after the jump");

	property p_sub;
		@(posedge sys_clk) disable iff (!arst_n)
		s_step_sub |=> $stable(presc_q);
	endproperty
	a_sub: assert property (p_sub)
		else $error("remove step did not swallow a cycle");

	property p_load;
		@(posedge sys_clk) disable iff (!arst_n)
		corr_evt |=> pend_q == {$past(trim_q.step), 1'b0};
	endproperty
	a_load: assert property (p_load)
		else $error("correction not two cycles per step");

	property p_zero;
		@(posedge sys_clk) disable iff (!arst_n)
		trim_q.step == 7'h00 && pend_q == 8'h00 && tick |=>
			presc_q == PRESC_W'($past(presc_q) + PRESC_W'(1));
	endproperty
	a_zero: assert property (p_zero)
		else $error("trim applied with zero step count");

	property p_coarse_event;
		@(posedge sys_clk) disable iff (!arst_n)
		ctrl_q.coarse && tick && c128 |-> corr_evt;
	endproperty
	a_coarse_event: assert property (p_coarse_event)
		else $error("coarse event missed at 128 Hz boundary");

	property p_pend_bound;
		@(posedge sys_clk) disable iff (!arst_n)
		pend_q <= PEND_MAX;
	endproperty
	a_pend_bound: assert property (p_pend_bound)
		else $error("pending cycles exceed 254");

	property p_backup_trim;
		@(posedge sys_clk) disable iff (!arst_n)
		on_backup and s_step_sub |=> pend_q == $past(pend_q) - 8'h01;
	endproperty
	a_backup_trim: assert property (p_backup_trim)
		else $error("trim stalled on backup supply");

	property p_sqw64;
		@(posedge sys_clk) disable iff (!arst_n)
		ctrl_q.coarse && ctrl_q.square_wave_output_enable && !on_backup |=>
			mfp_oe == !$past(presc_q[SQW_64HZ_BIT]);
	endproperty
	a_sqw64: assert property (p_sqw64)
		else $error("coarse square wave not on pin");

	property p_backup_off;
		@(posedge sys_clk) disable iff (!arst_n)
		on_backup [*2] |-> !mfp_oe;
	endproperty
	a_backup_off: assert property (p_backup_off)
		else $error("pin driven on backup supply");

	property p_trim_wr;
		@(posedge sys_clk) disable iff (!arst_n)
		reg_wr && reg_addr == ADDR_TRIM ##1 reg_addr == ADDR_TRIM |=>
			reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_trim_wr: assert property (p_trim_wr)
		else $error("trim register readback mismatch");

	property p_ctrl_field;
		@(posedge sys_clk) disable iff (!arst_n)
		reg_wr && reg_addr == ADDR_CTRL |=>
			ctrl_q.coarse == $past(reg_wdata[CTRL_CRS_BIT]) &&
			ctrl_q.square_wave_output_enable == $past(reg_wdata[CTRL_SQUARE_WAVE_OUTPUT_ENABLE_BIT]) &&
			ctrl_q.external_clock_input_select == $past(reg_wdata[CTRL_EXTERNAL_CLOCK_INPUT_SELECT_BIT]);
	endproperty
	a_ctrl_field: assert property (p_ctrl_field)
		else $error("control field position wrong");

endmodule : rtdt_trim

// ### rtdt_osc_model.sv
`timescale 1ns/1ps
// ****************************************
// oscillator sources seen by the trim unit
// ****************************************
// ticks far faster than real so a coarse period fits a short run
module rtdt_osc_model (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// oscillator pulses
	output logic      xtal_tick,
	output logic      ext_tick,
	output logic      osc_level
);
	logic       ph_q;
	logic [1:0] ext_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) ph_q <= 1'b0;
		else ph_q <= ~ph_q;
	end

	// rate differs from the crystal so a wrong source select shows
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) ext_q <= 2'h0;
		else ext_q <= (ext_q == 2'h2) ? 2'h0 : ext_q + 2'h1;
	end

	assign xtal_tick = ph_q;
	assign osc_level = ph_q;
	assign ext_tick  = (ext_q == 2'h2);
endmodule : rtdt_osc_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench import rtdt_pkg::*;;
	// ****************************************
	// signals
	// ****************************************
	logic       sys_clk = 1'b0;
	logic       arst_n, xtal_tick, ext_tick, osc_level;
	logic       oscillator_start, on_backup, reg_wr;
	logic       sec_tick, min_tick, mfp_o, mfp_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int         fail_count, n_checks;
	int         cyc = 0;

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	rtdt_osc_model osc (.sys_clk(sys_clk), .arst_n(arst_n),
		.xtal_tick(xtal_tick), .ext_tick(ext_tick), .osc_level(osc_level));

	rtdt_trim #(.MIN_SECONDS(2)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
		.xtal_tick(xtal_tick), .ext_tick(ext_tick), .osc_level(osc_level),
		.oscillator_start(oscillator_start), .on_backup(on_backup),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sec_tick(sec_tick), .min_tick(min_tick),
		.mfp_o(mfp_o), .mfp_oe(mfp_oe));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		repeat (2) @(posedge sys_clk);
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic rise(output int t);
		logic p;
		p = mfp_oe;
		t = -1;
		for (int i = 0; i < 5000 && t < 0; i++) begin
			@(posedge sys_clk);
			#1;
			if (p === 1'b0 && mfp_oe === 1'b1) t = cyc;
			p = mfp_oe;
		end
	endtask : rise

	// first full period skipped: a register write lands mid-period
	task automatic period(output logic [31:0] v);
		int t0, t1;
		rise(t0);
		rise(t0);
		rise(t1);
		v = t1 - t0;
	endtask : period

	task automatic rises(int n, output logic [31:0] c);
		logic p;
		p = mfp_oe;
		c = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			if (p === 1'b0 && mfp_oe === 1'b1) c++;
			p = mfp_oe;
		end
	endtask : rises

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		logic [7:0] d;
		rd(ADDR_TRIM, d);
		check("trim reset", d, TRIM_RST);
		rd(ADDR_CTRL, d);
		check("ctrl reset", d, CTRL_RST);
		wr(ADDR_TRIM, 8'h85);
		wr(8'h05, 8'hff);
		rd(ADDR_TRIM, d);
		check("trim rw", d, 8'h85);
		rd(8'h05, d);
		check("unmapped", d, 8'h00);
		wr(ADDR_CTRL, 8'h4e);
		rd(ADDR_CTRL, d);
		check("ctrl rw", d, 8'h4e);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_TRIM, 8'h00);
	endtask : t_regs

	task automatic t_sqw;
		logic [31:0] v;
		wr(ADDR_CTRL, 8'h42);
		// the pin follows the control write one cycle later
		repeat (2) @(posedge sys_clk);
		#1;
		rises(100, v);
		check("stopped osc", v, 32'h0);
		oscillator_start = 1'b1;
		wr(ADDR_CTRL, 8'h40);
		repeat (4) @(posedge sys_clk);
		#1;
		check("1 Hz level", mfp_oe, 32'h1);
		for (int f = 1; f < 4; f++) begin
			wr(ADDR_CTRL, 8'h40 | 8'(f));
			period(v);
			check("sqw period", v, (f == 3) ? 2 : 32 >> f);
		end
		wr(ADDR_CTRL, 8'h4a);
		period(v);
		check("ext clock period", v, 32'd12);
	endtask : t_sqw

	task automatic t_coarse;
		logic [7:0]  tv [5] = '{8'h00, 8'h80, 8'hbf, 8'h3f, 8'h7f};
		logic [31:0] v;
		int          e;
		wr(ADDR_CTRL, 8'h44);
		foreach (tv[i]) begin
			wr(ADDR_TRIM, tv[i]);
			e = 2 * (512 + (tv[i][7] ? -4 : 4) * int'(tv[i][6:0]));
			period(v);
			check("coarse period", v, e);
		end
	endtask : t_coarse

	task automatic t_backup;
		logic [31:0] v;
		wr(ADDR_TRIM, 8'h3f);
		on_backup = 1'b1;
		rises(3000, v);
		check("backup rises", v, 32'h0);
		check("backup pin", mfp_oe, 32'h0);
		on_backup = 1'b0;
		period(v);
		check("trim after backup", v, 32'd1528);
		wr(ADDR_CTRL, 8'h04);
		rises(2000, v);
		check("sqw disabled", v, 32'h0);
		check("pin idle", {mfp_oe, mfp_o}, 32'h0);
		wr(ADDR_CTRL, 8'h00);
	endtask : t_backup

	// second reset mid-run, then the largest add so a second is short
	task automatic t_second;
		logic [7:0] d;
		int         t [2];
		logic       m [2];
		arst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		rd(ADDR_TRIM, d);
		check("trim after reset", d, TRIM_RST);
		wr(ADDR_TRIM, 8'h80 | 8'(130 * 32768 * 60 / 2000000));
		wr(ADDR_CTRL, 8'h04);
		foreach (t[i]) begin
			t[i] = -1;
			for (int k = 0; k < 3000 && t[i] < 0; k++) begin
				@(posedge sys_clk);
				#1;
				if (sec_tick === 1'b1) t[i] = cyc;
			end
			m[i] = min_tick;
		end
		check("second", t[1] - t[0],
			2 * COARSE_HZ * (COARSE_TICKS - CYC_PER_STEP * 127));
		check("minute", {m[0], m[1]}, 32'h1);
		wr(ADDR_CTRL, 8'h00);
	endtask : t_second

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		oscillator_start = 1'b0;
		on_backup = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (3) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		t_regs();
		t_sqw();
		t_coarse();
		t_backup();
		t_second();
		final_report();
	end

	// whole run needs some 28k cycles
	initial begin
		#1_000_000;
		fail_count++;
		final_report();
	end
endmodule : testbench
